// ### design/hcps_top.sv
// hall commutation and pwm steering core with its AHB-Lite register slave
// assumes hall and brake pins are asynchronous; adc words arrive on this clock
`include "hcps_regs.svh"
module hcps_top
	import hcps_pkg::*;
#(
	parameter int SPEED_WIN_CYC = (`HCPS_SPEED_WIN_NS * 1000) / `HCPS_CLK_PS,
	parameter int ADC_W         = 12
) (
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic              hsel_in,
	input  wire logic [31:0]       haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [31:0]       hwdata_in,
	input  wire logic              hready_in,
	output logic      [31:0]       hrdata_out,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	input  wire logic [2:0]        hall_abc_in,
	input  wire logic              brake_in,
	input  wire logic              adc_valid_in,
	input  wire logic [ADC_W-1:0]  adc_bat_in,
	input  wire logic [ADC_W-1:0]  adc_thr_in,
	input  wire logic [ADC_W-1:0]  adc_cur_in,
	output logic      [2:0]        gate_high_out,
	output logic      [2:0]        gate_low_out,
	output logic                   hall_fault_out
);
	logic [3:0]       pins_s;
	logic [2:0]       hall_s;
	logic             brake_s;
	logic [2:0]       hall_prev_q;
	logic             load_pend_q;
	logic             hall_evt;
	logic             hall_ok;
	hcps_steer_t      steer_q;
	hcps_dir_e        dir_q;
	logic [3:0]       ctrl_q;
	logic [15:0]      duty_q;
	logic [15:0]      period_q;
	logic             brk_seen_q;
	logic             brake_act;
	logic             drive_ok;
	logic             pwm;
	logic             pwm_start;
	logic [31:0]      win_q;
	logic             win_end;
	logic [15:0]      evt_cnt_q;
	logic [15:0]      speed_q;
	logic [ADC_W-1:0] adc_bat_q;
	logic [ADC_W-1:0] adc_thr_q;
	logic [ADC_W-1:0] adc_cur_q;
	logic             wr_pend_q;
	logic [7:0]       wr_addr_q;
	logic             addr_ok;
	logic             wr_steer;

	hcps_sync #(
		.W (4)
	) u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     ({hall_abc_in, brake_in}),
		.q_out    (pins_s)
	);

	hcps_pwm #(
		.W (16)
	) u_pwm (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.period_in (period_q),
		.duty_in   (duty_q),
		.pwm_out   (pwm),
		.start_out (pwm_start)
	);

	assign hall_s    = pins_s[3:1];
	assign brake_s   = pins_s[0];
	assign hall_evt  = (hall_s != hall_prev_q);
	assign hall_ok   = hcps_valid(hall_s);
	assign brake_act = ctrl_q[`HCPS_CTRL_BRK_POL] ? brake_s : ~brake_s;
	assign drive_ok  = ctrl_q[`HCPS_CTRL_EN] && !brake_act && !hall_fault_out;
	assign win_end   = (win_q >= 32'(SPEED_WIN_CYC - 1));
	assign addr_ok   = hsel_in && htrans_in[1] && hready_in;
	assign wr_steer  = wr_pend_q && (wr_addr_q == `HCPS_ADDR_STEER);

	// ---------------- bus slave ----------------
	// zero wait states: read data is picked in the address phase
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			hrdata_out    <= 32'h0000_0000;
			wr_pend_q     <= 1'b0;
			wr_addr_q     <= 8'h00;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			wr_pend_q     <= addr_ok && hwrite_in;
			wr_addr_q     <= haddr_in[7:0];
			hrdata_out    <= 32'h0000_0000;
			if (addr_ok && !hwrite_in && (haddr_in[31:8] == 24'h00_0000)) begin
				if (haddr_in[7:0] == `HCPS_ADDR_CTRL) begin
					hrdata_out <= {28'h000_0000, ctrl_q};
				end else if (haddr_in[7:0] == `HCPS_ADDR_DUTY) begin
					hrdata_out <= {16'h0000, duty_q};
				end else if (haddr_in[7:0] == `HCPS_ADDR_PERIOD) begin
					hrdata_out <= {16'h0000, period_q};
				end else if (haddr_in[7:0] == `HCPS_ADDR_STEER) begin
					hrdata_out <= {24'h00_0000, steer_q};
				end else if (haddr_in[7:0] == `HCPS_ADDR_STATUS) begin
					hrdata_out <= {25'h000_0000, brk_seen_q, dir_q, brake_act, hall_fault_out, hall_s};
				end else if (haddr_in[7:0] == `HCPS_ADDR_SPEED) begin
					hrdata_out <= {16'h0000, speed_q};
				end else if (haddr_in[7:0] == `HCPS_ADDR_ADC_BAT) begin
					hrdata_out <= 32'(adc_bat_q);
				end else if (haddr_in[7:0] == `HCPS_ADDR_ADC_THR) begin
					hrdata_out <= 32'(adc_thr_q);
				end else if (haddr_in[7:0] == `HCPS_ADDR_ADC_CUR) begin
					hrdata_out <= 32'(adc_cur_q);
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_q   <= `HCPS_CTRL_RST;
			duty_q   <= `HCPS_DUTY_RST;
			period_q <= `HCPS_PERIOD_RST;
		end else if (wr_pend_q) begin
			if (wr_addr_q == `HCPS_ADDR_CTRL) begin
				ctrl_q <= hwdata_in[3:0];
			end else if (wr_addr_q == `HCPS_ADDR_DUTY) begin
				duty_q <= hwdata_in[15:0];
			end else if (wr_addr_q == `HCPS_ADDR_PERIOD) begin
				period_q <= hwdata_in[15:0];
			end
		end
	end

	// brake seen: set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			brk_seen_q <= 1'b0;
		end else if (brake_act) begin
			brk_seen_q <= 1'b1;
		end else if (wr_pend_q && (wr_addr_q == `HCPS_ADDR_STATUS) && hwdata_in[`HCPS_ST_BRK_SEEN]) begin
			brk_seen_q <= 1'b0;
		end
	end

	// ---------------- commutation ----------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			hall_prev_q <= 3'h0;
			load_pend_q <= 1'b1;
		end else begin
			hall_prev_q <= hall_s;
			load_pend_q <= load_pend_q && !hall_ok;
		end
	end

	// table and direction sampled only on a hall event or the first valid state
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			steer_q <= `HCPS_STEER_RST;
			dir_q   <= HCPS_FWD;
		end else if (!hall_ok) begin
			steer_q <= `HCPS_STEER_RST;
		end else if ((hall_evt || load_pend_q) && !ctrl_q[`HCPS_CTRL_MANUAL]) begin
			dir_q   <= hcps_dir_e'(ctrl_q[`HCPS_CTRL_DIR]);
			steer_q <= hcps_decode(hall_s, hcps_dir_e'(ctrl_q[`HCPS_CTRL_DIR]));
		end else if (wr_steer && ctrl_q[`HCPS_CTRL_MANUAL]) begin
			// software codes only land in manual mode, so auto steering stays table-driven
			steer_q <= hwdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			hall_fault_out <= 1'b0;
		end else begin
			hall_fault_out <= !hall_ok;
		end
	end

	// high side chops with pwm, low side held on for the whole step
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			gate_high_out <= 3'h0;
			gate_low_out  <= 3'h0;
		end else if (drive_ok) begin
			gate_high_out <= {steer_q[7], steer_q[4], steer_q[1]} & {3{pwm}};
			gate_low_out  <= {steer_q[6], steer_q[3], steer_q[0]};
		end else begin
			gate_high_out <= 3'h0;
			gate_low_out  <= 3'h0;
		end
	end

	// ---------------- speed and adc ----------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			win_q     <= 32'h0000_0000;
			evt_cnt_q <= 16'h0000;
			speed_q   <= 16'h0000;
		end else if (win_end) begin
			win_q     <= 32'h0000_0000;
			evt_cnt_q <= 16'h0000;
			speed_q   <= evt_cnt_q + {15'h0000, hall_evt};
		end else begin
			win_q     <= win_q + 32'h0000_0001;
			evt_cnt_q <= evt_cnt_q + {15'h0000, hall_evt};
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			adc_bat_q <= '0;
			adc_thr_q <= '0;
			adc_cur_q <= '0;
		end else if (adc_valid_in) begin
			adc_bat_q <= adc_bat_in;
			adc_thr_q <= adc_thr_in;
			adc_cur_q <= adc_cur_in;
		end
	end

	// ---------------- checks ----------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_fwd_first: assert property (
		hall_evt && hall_s == 3'b001 && !ctrl_q[1] && !ctrl_q[3] |=> steer_q == `HCPS_STEP_CH_BL)
		else $error("forward 001 code wrong");
	a_fwd_fourth: assert property (
		hall_evt && hall_s == 3'b110 && !ctrl_q[1] && !ctrl_q[3] |=> steer_q == `HCPS_STEP_BH_CL)
		else $error("forward 110 code wrong");
	a_rev_first: assert property (
		hall_evt && hall_s == 3'b001 && ctrl_q[1] && !ctrl_q[3] |=> steer_q == `HCPS_STEP_BH_CL)
		else $error("reverse 001 code wrong");
	a_rev_fourth: assert property (
		hall_evt && hall_s == 3'b110 && ctrl_q[1] && !ctrl_q[3] |=> steer_q == `HCPS_STEP_CH_BL)
		else $error("reverse 110 code wrong");
	a_unused_bits_set: assert property (
		!ctrl_q[3] && steer_q != 8'h00 |-> steer_q[5] && steer_q[2])
		else $error("unused steering bits not one");
	a_step_holds: assert property (
		!hall_evt && !load_pend_q && hall_ok && !wr_steer |=> $stable(steer_q))
		else $error("steering changed without hall event");
	a_brake_off: assert property (
		brake_act |=> gate_high_out == 3'h0 && gate_low_out == 3'h0)
		else $error("gates on during brake");
	a_speed_report: assert property (
		win_end |=> speed_q == $past(evt_cnt_q) + {15'h0000, $past(hall_evt)})
		else $error("speed count wrong");
	a_adc_capture: assert property (
		adc_valid_in |=> adc_cur_q == $past(adc_cur_in))
		else $error("adc reading not captured");
	// gates lag the fault flag by one cycle; a one-cycle invalid state still drops them
	a_invalid_off: assert property (
		!hall_ok |=> hall_fault_out ##1 (gate_high_out == 3'h0 && gate_low_out == 3'h0))
		else $error("invalid hall not forced off");
	a_two_switches: assert property (
		!ctrl_q[3] |-> $onehot0(gate_high_out) && $onehot0(gate_low_out))
		else $error("more than two switches on");
	a_dir_at_event: assert property (
		!hall_evt && !load_pend_q |=> $stable(dir_q))
		else $error("direction changed without hall event");
	a_fwd_second: assert property (
		hall_evt && hall_s == 3'b101 && !ctrl_q[1] && !ctrl_q[3] |=> steer_q == `HCPS_STEP_AH_BL)
		else $error("forward 101 code wrong");
	a_rev_second: assert property (
		hall_evt && hall_s == 3'b101 && ctrl_q[1] && !ctrl_q[3] |=> steer_q == `HCPS_STEP_AH_CL)
		else $error("reverse 101 code wrong");
	a_steer_cleared: assert property (
		!hall_ok |=> steer_q == `HCPS_STEER_RST)
		else $error("invalid hall used for position");
	a_enable_off: assert property (
		!ctrl_q[`HCPS_CTRL_EN] |=> gate_high_out == 3'h0 && gate_low_out == 3'h0)
		else $error("gates on while disabled");
	a_high_chopped: assert property (
		!pwm |=> gate_high_out == 3'h0)
		else $error("high side on outside pwm pulse");
	a_low_full_duty: assert property (
		drive_ok && hall_ok && steer_q != 8'h00 && !ctrl_q[3] |=> $onehot(gate_low_out))
		else $error("low side not held on");
	a_brake_sticky: assert property (
		brake_act |=> brk_seen_q)
		else $error("brake seen flag not set");
	a_speed_clear: assert property (
		win_end |=> evt_cnt_q == 16'h0000)
		else $error("event count not restarted");

	c_fwd_step: cover property (hall_evt && hall_ok && !ctrl_q[1] ##1 |gate_low_out);
	c_rev_step: cover property (hall_evt && hall_ok && ctrl_q[1]);
	c_fault: cover property (hall_fault_out ##1 !hall_fault_out);
	c_speed: cover property (win_end && evt_cnt_q != 16'h0000);
	c_brake: cover property (brake_act ##1 !brake_act);
endmodule

// ### common/hcps_regs.svh
// register map, field positions, reset values and timing counts of the hall commutation block
// assumes a 250 MHz clock and a 32-bit AHB-Lite register bus
// Function
// - forward: hall 001, 101, 100 load codes 2E, AC, A5
// - forward: hall 110, 010, 011 load codes 35, 74, 66
// - reverse: hall 001, 101, 100 load codes 35, A5, AC
// - reverse: hall 110, 010, 011 load codes 2E, 66, 74
// - bits 5 and 2 are unused in this mode and held at one
// - three hall event inputs; any edge updates the commutation step
// - a fourth event input carries the brake and stops drive
// - count hall events per fixed window and report the count
// - pwm outputs drive the bridge; commanded duty sets speed
// - accept battery, throttle and current readings for the control logic
// - rising and falling edges of every hall input are events
// - hall 000 and 111 are invalid and never used for position
// - exactly two switches conduct: high side pwm, low side full duty
// - all pwm outputs share one period start; duty changes there only
`ifndef HCPS_REGS_SVH
`define HCPS_REGS_SVH

`define HCPS_ADDR_CTRL     8'h00
`define HCPS_ADDR_DUTY     8'h04
`define HCPS_ADDR_PERIOD   8'h08
`define HCPS_ADDR_STEER    8'h0C
`define HCPS_ADDR_STATUS   8'h10
`define HCPS_ADDR_SPEED    8'h14
`define HCPS_ADDR_ADC_BAT  8'h18
`define HCPS_ADDR_ADC_THR  8'h1C
`define HCPS_ADDR_ADC_CUR  8'h20

`define HCPS_CTRL_EN       0
`define HCPS_CTRL_DIR      1
`define HCPS_CTRL_BRK_POL  2
`define HCPS_CTRL_MANUAL   3
`define HCPS_CTRL_RST      4'h4

`define HCPS_ST_FAULT      3
`define HCPS_ST_BRAKE      4
`define HCPS_ST_DIR        5
`define HCPS_ST_BRK_SEEN   6

`define HCPS_DUTY_RST      16'h0000
`define HCPS_PERIOD_RST    16'h30D3
`define HCPS_STEER_RST     8'h00

`define HCPS_STEP_CH_BL    8'h2E
`define HCPS_STEP_AH_BL    8'hAC
`define HCPS_STEP_AH_CL    8'hA5
`define HCPS_STEP_BH_CL    8'h35
`define HCPS_STEP_BH_AL    8'h74
`define HCPS_STEP_CH_AL    8'h66

`define HCPS_CLK_PS        4000
`define HCPS_SPEED_WIN_NS  1000000

`endif

// ### common/hcps_pkg.sv
// types and the hall decode function of the hall commutation block
// assumes hcps_regs.svh is on the include path
`include "hcps_regs.svh"
package hcps_pkg;
	typedef enum logic {HCPS_FWD, HCPS_REV} hcps_dir_e;
	typedef logic [7:0] hcps_steer_t;

	function automatic logic hcps_valid(input logic [2:0] abc);
		hcps_valid = (abc != 3'h0) && (abc != 3'h7);
	endfunction

	// zero for the two invalid combinations
	function automatic hcps_steer_t hcps_decode(input logic [2:0] abc, input hcps_dir_e dir);
		hcps_decode = `HCPS_STEER_RST;
		case (abc)
			3'b001: hcps_decode = (dir == HCPS_FWD) ? `HCPS_STEP_CH_BL : `HCPS_STEP_BH_CL;
			3'b101: hcps_decode = (dir == HCPS_FWD) ? `HCPS_STEP_AH_BL : `HCPS_STEP_AH_CL;
			3'b100: hcps_decode = (dir == HCPS_FWD) ? `HCPS_STEP_AH_CL : `HCPS_STEP_AH_BL;
			3'b110: hcps_decode = (dir == HCPS_FWD) ? `HCPS_STEP_BH_CL : `HCPS_STEP_CH_BL;
			3'b010: hcps_decode = (dir == HCPS_FWD) ? `HCPS_STEP_BH_AL : `HCPS_STEP_CH_AL;
			3'b011: hcps_decode = (dir == HCPS_FWD) ? `HCPS_STEP_CH_AL : `HCPS_STEP_BH_AL;
			default: hcps_decode = `HCPS_STEER_RST;
		endcase
	endfunction
endpackage

// ### design/hcps_sync.sv
// two-flop synchroniser for pin inputs
// assumes nothing but the block clock and reset
module hcps_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule

// ### design/hcps_pwm.sv
// edge-aligned pwm timebase shared by the three high-side bridge outputs
// assumes period and duty come from registers on the same clock
module hcps_pwm #(
	parameter int W = 16
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic [W-1:0] period_in,
	input  wire logic [W-1:0] duty_in,
	output logic              pwm_out,
	output logic              start_out
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] duty_sh_q;
	logic         wrap;

	assign wrap = (cnt_q >= period_in);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_q <= '0;
		end else if (wrap) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// duty only moves at the shared start so no output glitches mid-period
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			duty_sh_q <= '0;
			start_out <= 1'b0;
			pwm_out   <= 1'b0;
		end else begin
			start_out <= wrap;
			if (wrap) begin
				duty_sh_q <= duty_in;
			end
			pwm_out <= wrap ? (duty_in != '0) : ((cnt_q + 1'b1) < duty_sh_q);
		end
	end

	a_duty_at_start: assert property (@(posedge clk_in) disable iff (reset_in)
		!wrap |=> $stable(duty_sh_q)) else $error("duty shadow moved off period start");
endmodule

// ### tb/hcps_hall_model.sv
// hall sensor model: holds a commanded state or spins forward at a fixed step rate
// assumes the bench clock and reset; the bridge side is watched by the bench itself
module hcps_hall_model #(
	parameter int STEP = 20
) (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       run_in,
	input  wire logic [2:0] set_in,
	output logic      [2:0] hall_abc_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] idx_q;
	int         cnt_q;

	// one line flips per step, so each step is exactly one edge
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			idx_q <= 3'h0;
			cnt_q <= 0;
		end else if (!run_in) begin
			idx_q <= 3'h0;
			cnt_q <= 0;
		end else if (cnt_q == STEP - 1) begin
			cnt_q <= 0;
			idx_q <= (idx_q == 3'h5) ? 3'h0 : idx_q + 3'h1;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end

	always_comb begin
		case (idx_q)
			3'h0: hall_abc_out = run_in ? 3'b001 : set_in;
			3'h1: hall_abc_out = run_in ? 3'b101 : set_in;
			3'h2: hall_abc_out = run_in ? 3'b100 : set_in;
			3'h3: hall_abc_out = run_in ? 3'b110 : set_in;
			3'h4: hall_abc_out = run_in ? 3'b010 : set_in;
			default: hall_abc_out = run_in ? 3'b011 : set_in;
		endcase
	end
endmodule

// ### tb/hall_commutation_pwm_steering_test.sv
// self-checking bench of the hall commutation core over its AHB-Lite port
// assumes one clock, a single bus master and the hall model beside the core
`include "hcps_regs.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module hall_commutation_pwm_steering_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WIN = 200;
	logic        clk_in    = 1'b0;
	logic        reset_in  = 1'b1;
	logic [31:0] haddr     = 32'h0;
	logic [31:0] hwdata    = 32'h0;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic        brake     = 1'b0;
	logic        adc_valid = 1'b0;
	logic [11:0] adc_bat   = 12'h0;
	logic [11:0] adc_thr   = 12'h0;
	logic [11:0] adc_cur   = 12'h0;
	logic        run       = 1'b0;
	logic [2:0]  set_abc   = 3'b011;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hready;
	logic        hresp;
	logic [2:0]  hall;
	logic [2:0]  gate_high;
	logic [2:0]  gate_low;
	logic        fault;
	int          n_mismatch      = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	int          n_on            = 0;
	logic [2:0]  seq [6] = '{3'b001, 3'b101, 3'b100, 3'b110, 3'b010, 3'b011};

	always #2 clk_in = ~clk_in;

	hcps_top #(.SPEED_WIN_CYC(WIN), .ADC_W(12)) u_dut (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(1'b1),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.hall_abc_in(hall), .brake_in(brake), .adc_valid_in(adc_valid), .adc_bat_in(adc_bat),
		.adc_thr_in(adc_thr), .adc_cur_in(adc_cur), .gate_high_out(gate_high), .gate_low_out(gate_low),
		.hall_fault_out(fault));

	hcps_hall_model #(.STEP(WIN / 10)) u_hall (.clk_in(clk_in), .reset_in(reset_in), .run_in(run),
		.set_in(set_abc), .hall_abc_out(hall));

	function automatic logic [7:0] code(input logic [2:0] h, input logic rev);
		case (h)
			3'b001: code = rev ? 8'h35 : 8'h2E;
			3'b101: code = rev ? 8'hA5 : 8'hAC;
			3'b100: code = rev ? 8'hAC : 8'hA5;
			3'b110: code = rev ? 8'h2E : 8'h35;
			3'b010: code = rev ? 8'h66 : 8'h74;
			3'b011: code = rev ? 8'h74 : 8'h66;
			default: code = 8'h00;
		endcase
	endfunction

	// gate pairs as the bridge sees them: high side A,B,C then low side A,B,C
	function automatic logic [5:0] gates(input logic [7:0] c);
		gates = {c[7], c[4], c[1], c[6], c[3], c[0]};
	endfunction

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_in);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk_in); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	task automatic end_sim();
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ceiling well above the roughly nine hundred cycles the sequence needs
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		rchk(`HCPS_ADDR_CTRL, 32'h4);
		rchk(`HCPS_ADDR_DUTY, 32'h0);
		rchk(`HCPS_ADDR_PERIOD, 32'h30D3);
		bus(1'b1, 8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'h0);
		`CHK(hresp, 1'b0)
		bus(1'b1, `HCPS_ADDR_PERIOD, 32'h9);
		bus(1'b1, `HCPS_ADDR_DUTY, 32'hFFFF);
		for (int d = 0; d < 2; d++) begin
			bus(1'b1, `HCPS_ADDR_CTRL, 32'h5 | (d << 1));
			// new direction waits for a hall edge
			rchk(`HCPS_ADDR_STEER, {24'h0, code(3'b011, 1'b0)});
			for (int i = 0; i < 6; i++) begin
				set_abc <= seq[i];
				repeat (6) @(posedge clk_in);
				rchk(`HCPS_ADDR_STEER, {24'h0, code(seq[i], d[0])});
				`CHK({gate_high, gate_low}, gates(code(seq[i], d[0])))
			end
		end
		bus(1'b1, `HCPS_ADDR_DUTY, 32'h0);
		repeat (25) @(posedge clk_in);
		`CHK({gate_high, gate_low}, {3'h0, gates(8'h74)} & 6'h07)
		for (int v = 0; v < 8; v += 7) begin
			set_abc <= v[2:0];
			repeat (6) @(posedge clk_in);
			`CHK({fault, gate_high, gate_low}, 7'h40)
			rchk(`HCPS_ADDR_STEER, 32'h0);
			rchk(`HCPS_ADDR_STATUS, 32'h28 | v);
		end
		set_abc <= 3'b101;
		bus(1'b1, `HCPS_ADDR_DUTY, 32'hFFFF);
		repeat (25) @(posedge clk_in);
		`CHK({fault, gate_high, gate_low}, {1'b0, gates(8'hA5)})
		brake <= 1'b1;
		repeat (6) @(posedge clk_in);
		`CHK({gate_high, gate_low}, 6'h00)
		rchk(`HCPS_ADDR_STATUS, 32'h75);
		brake <= 1'b0;
		repeat (6) @(posedge clk_in);
		rchk(`HCPS_ADDR_STATUS, 32'h65);
		bus(1'b1, `HCPS_ADDR_STATUS, 32'h40);
		rchk(`HCPS_ADDR_STATUS, 32'h25);
		`CHK({gate_high, gate_low}, gates(8'hA5))
		// duty 5 of a 10-cycle period: high side A on for exactly 5 cycles
		bus(1'b1, `HCPS_ADDR_DUTY, 32'h5);
		repeat (25) @(posedge clk_in);
		n_on = 0;
		repeat (10) begin
			@(posedge clk_in);
			n_on += (gate_high === 3'b100);
		end
		`CHK(n_on, 5)
		// three windows so the last finished one saw only steady steps
		run <= 1'b1;
		repeat (3 * WIN) @(posedge clk_in);
		rchk(`HCPS_ADDR_SPEED, 32'd10);
		run <= 1'b0;
		adc_bat <= 12'h123;
		adc_thr <= 12'hABC;
		adc_cur <= 12'hF0E;
		adc_valid <= 1'b1;
		@(posedge clk_in);
		adc_valid <= 1'b0;
		rchk(`HCPS_ADDR_ADC_BAT, 32'h123);
		rchk(`HCPS_ADDR_ADC_THR, 32'hABC);
		rchk(`HCPS_ADDR_ADC_CUR, 32'hF0E);
		end_sim();
	end
endmodule
